// ---- hdl/ufe_pkg.sv ----
package ufe_pkg;
    // apb register byte offsets
    localparam logic [7:0] CTRL_ONE_OFS   = 8'h00; // serial_control_one
    localparam logic [7:0] CTRL_TWO_OFS   = 8'h04; // serial_control_two
    localparam logic [7:0] DIVISOR_OFS    = 8'h08; // baud_divisor
    localparam logic [7:0] STATUS_OFS     = 8'h0c; // status, read only
    localparam logic [7:0] HOLD_OFS       = 8'h10; // transmit holding register, write only

    // serial_control_one fields
    localparam int SERIAL_ENABLE_BIT      = 7;
    localparam int NINE_BIT_SELECT_BIT    = 6;
    localparam int PARITY_ENABLE_BIT      = 5;
    localparam int PARITY_ODD_BIT         = 4;
    localparam int TWO_STOP_BIT           = 3;
    localparam int SEND_BREAK_BIT         = 2;
    localparam int TRANSMIT_NINTH_BIT     = 0;
    localparam logic [7:0] CTRL_ONE_RESET = 8'h00;

    // serial_control_two fields
    localparam int TRANSMIT_ENABLE_BIT    = 7;
    localparam int RECEIVE_ENABLE_BIT     = 6;
    localparam int BAUD_HIGH_SPEED_BIT    = 5;
    localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
    localparam logic [7:0] DIVISOR_RESET  = 8'h00;

    // status fields
    localparam int TX_EMPTY_BIT           = 0;
    localparam int TX_IDLE_BIT            = 1;
    localparam int RX_IDLE_BIT            = 2;
    localparam int RX_AVAIL_BIT           = 3;
    localparam int OVERRUN_BIT            = 4;
    localparam int FRAMING_BIT            = 5;
    localparam int PARITY_ERR_BIT         = 6;
    localparam int NOISE_BIT              = 7;
    localparam int RX_LEVEL_BIT           = 8;

    // baud generator prescale terminal counts
    localparam logic [5:0] PRESCALE_LOW_TC  = 6'h3f; // divide by 64
    localparam logic [5:0] PRESCALE_HIGH_TC = 6'h0f; // divide by 16

    // frame lengths in bit times
    localparam logic [4:0] START_BITS     = 5'h01;
    localparam logic [4:0] DATA_BITS_8    = 5'h08;
    localparam logic [4:0] DATA_BITS_9    = 5'h09;
    localparam logic [4:0] BREAK_LOW_BITS = 5'h0e; // start bit plus 13 zeros

    typedef enum logic [1:0] {
        UFE_TX_IDLE,
        UFE_TX_WAIT,
        UFE_TX_SEND
    } ufe_tx_state_e;
endpackage : ufe_pkg

// ---- hdl/ufe_uart.sv ----
// Overview of operation
// [R1] nrz frame: start, 8/9 data, 1/2 stop
// [R2] even, odd or no parity selectable
// [R3] reset format is 8 data, no parity, 1 stop
// [R4] data bits sent lsb first
// [R5] one format and baud shared by both directions
// [R6] 8-bit divisor, low speed fclk/(64(n+1))
// [R7] high speed gives fclk/(16(n+1))
// [R8] pins owned when serial, tx, rx enabled
// [R9] tx rests high when no frame
// [R10] serial disable releases pins, empties buffers
// [R11] disable clears/sets listed flags, keeps config
// [R12] disable aborts activity, re-enable keeps config
// [R13] nine-bit mode msb from ninth-bit field
// [R14] parity or address takes last data bit
// [R15] stop count independent of data length
// [R16] every frame carries stop bits
// [R17] shifter reloads only after stop bit sent
// [R18] start needs data and baud tick
// [R19] write with shifter empty loads it directly
// [R20] transmit disable aborts, resets, releases pin
// [R21] shift register not software visible
// [R22] empty flag set when holding register free
// [R23] parity covers preceding data bits
// [R24] divisor reloads, tick every n+1 prescales
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module ufe_uart (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // serial pins
    output logic             tx_out,
    output logic             tx_oe,
    input  wire logic        rx_in,
    output logic             rx_sel
);

    logic [7:0]          ctrl_one_r;
    logic [7:0]          ctrl_two_r;
    logic [7:0]          baud_divisor_r;
    logic [7:0]          hold_r;
    logic                hold_ninth_r;
    logic                hold_full_r;
    logic                tx_empty_flag_r;
    logic                tx_idle_flag_r;
    logic                ack_r;
    logic [31:0]         prdata_r;
    logic                rx_meta_r;
    logic                rx_sync_r;
    logic [5:0]          prescale_r;
    logic [7:0]          div_cnt_r;
    logic                baud_tick;
    logic [10:0]         tsr_r;
    logic                tsr_break_r;
    logic [4:0]          bit_cnt_r;
    logic [4:0]          frame_len;
    ufe_pkg::ufe_tx_state_e tx_state_r;

    // control fields
    logic serial_enable;
    logic nine_bit_select;
    logic parity_enable;
    logic parity_odd_even_select;
    logic two_stop_select;
    logic send_break;
    logic transmit_ninth_bit;
    logic transmit_enable;
    logic receive_enable;
    logic baud_high_speed;

    assign serial_enable          = ctrl_one_r[ufe_pkg::SERIAL_ENABLE_BIT];
    assign nine_bit_select        = ctrl_one_r[ufe_pkg::NINE_BIT_SELECT_BIT];
    assign parity_enable          = ctrl_one_r[ufe_pkg::PARITY_ENABLE_BIT];
    assign parity_odd_even_select = ctrl_one_r[ufe_pkg::PARITY_ODD_BIT];
    assign two_stop_select        = ctrl_one_r[ufe_pkg::TWO_STOP_BIT];
    assign send_break             = ctrl_one_r[ufe_pkg::SEND_BREAK_BIT];
    assign transmit_ninth_bit     = ctrl_one_r[ufe_pkg::TRANSMIT_NINTH_BIT];
    assign transmit_enable        = ctrl_two_r[ufe_pkg::TRANSMIT_ENABLE_BIT];
    assign receive_enable         = ctrl_two_r[ufe_pkg::RECEIVE_ENABLE_BIT];
    assign baud_high_speed        = ctrl_two_r[ufe_pkg::BAUD_HIGH_SPEED_BIT];

    // apb decode; one access cycle, answer prepared in the setup cycle
    logic acc;
    logic wr_acc;
    logic hit;
    logic tx_run;
    assign acc    = psel & penable & ack_r;
    assign wr_acc = acc & pwrite;
    assign hit    = (paddr == ufe_pkg::CTRL_ONE_OFS) | (paddr == ufe_pkg::CTRL_TWO_OFS) |
                    (paddr == ufe_pkg::DIVISOR_OFS) | (paddr == ufe_pkg::STATUS_OFS) |
                    (paddr == ufe_pkg::HOLD_OFS);
    assign pready  = acc;
    assign pslverr = acc & ~hit;
    assign prdata  = prdata_r;
    assign tx_run  = serial_enable & transmit_enable;

    // writes to the holding register are inhibited while it still holds data
    logic hold_wr;
    assign hold_wr = wr_acc & (paddr == ufe_pkg::HOLD_OFS) & serial_enable & tx_empty_flag_r;

    // shifter free means a write goes straight into it
    logic tsr_free;
    assign tsr_free = (tx_state_r == ufe_pkg::UFE_TX_IDLE);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= psel & ~penable;
        end
    end

    // read data captured at the setup edge; shift register has no address
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata_r <= 32'h0000_0000; // [R21]
            case (paddr)
                ufe_pkg::CTRL_ONE_OFS: prdata_r[7:0] <= ctrl_one_r;
                ufe_pkg::CTRL_TWO_OFS: prdata_r[7:0] <= ctrl_two_r;
                ufe_pkg::DIVISOR_OFS:  prdata_r[7:0] <= baud_divisor_r;
                ufe_pkg::STATUS_OFS: begin
                    // receiver is outside this block: its flags read cleared, idle set
                    prdata_r[ufe_pkg::TX_EMPTY_BIT] <= tx_empty_flag_r; // [R22]
                    prdata_r[ufe_pkg::TX_IDLE_BIT]  <= tx_idle_flag_r;
                    prdata_r[ufe_pkg::RX_IDLE_BIT]  <= 1'b1; // [R11]
                    prdata_r[ufe_pkg::RX_LEVEL_BIT] <= rx_sync_r;
                end
                default: prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // control one; clearing serial enable also drops send break
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_one_r <= ufe_pkg::CTRL_ONE_RESET; // [R3]
        end else if (wr_acc & (paddr == ufe_pkg::CTRL_ONE_OFS)) begin
            ctrl_one_r <= pwdata[7:0];
            if (!pwdata[ufe_pkg::SERIAL_ENABLE_BIT]) begin
                ctrl_one_r[ufe_pkg::SEND_BREAK_BIT] <= 1'b0; // [R11]
            end
        end
    end

    // control two; enables held clear while the port is off, speed bit kept
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_two_r <= ufe_pkg::CTRL_TWO_RESET;
        end else if (!serial_enable) begin
            ctrl_two_r[ufe_pkg::TRANSMIT_ENABLE_BIT] <= 1'b0; // [R11]
            ctrl_two_r[ufe_pkg::RECEIVE_ENABLE_BIT]  <= 1'b0; // [R11]
            if (wr_acc & (paddr == ufe_pkg::CTRL_TWO_OFS)) begin
                ctrl_two_r[ufe_pkg::BAUD_HIGH_SPEED_BIT] <= pwdata[ufe_pkg::BAUD_HIGH_SPEED_BIT];
            end
        end else if (wr_acc & (paddr == ufe_pkg::CTRL_TWO_OFS)) begin
            ctrl_two_r <= pwdata[7:0];
        end
    end

    // divisor survives disable so re-enable resumes the same rate
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            baud_divisor_r <= ufe_pkg::DIVISOR_RESET;
        end else if (wr_acc & (paddr == ufe_pkg::DIVISOR_OFS)) begin
            baud_divisor_r <= pwdata[7:0]; // [R12]
        end
    end

    // rx pin passes two flops before anything reads it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
        end else begin
            rx_meta_r <= rx_in;
            rx_sync_r <= rx_meta_r;
        end
    end

    // prescaler: 64 or 16 clocks, then the divisor counter; its tick drives only the transmit sequencer
    logic [5:0] prescale_tc;
    logic       prescale_end;
    assign prescale_tc  = baud_high_speed ? ufe_pkg::PRESCALE_HIGH_TC : ufe_pkg::PRESCALE_LOW_TC; // [R6] [R7]
    assign prescale_end = (prescale_r == prescale_tc);
    assign baud_tick    = prescale_end & (div_cnt_r == 8'h00); // [R5]

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_r <= 6'h00;
        end else if (!serial_enable | prescale_end) begin
            prescale_r <= 6'h00;
        end else begin
            prescale_r <= prescale_r + 6'h01;
        end
    end

    // down counter reloads the divisor at terminal count
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_r <= 8'h00;
        end else if (!serial_enable) begin
            div_cnt_r <= baud_divisor_r;
        end else if (prescale_end) begin
            div_cnt_r <= (div_cnt_r == 8'h00) ? baud_divisor_r : div_cnt_r - 8'h01; // [R24]
        end
    end

    // data word with parity or address in the last data position
    logic [7:0] src_data;
    logic       src_ninth;
    logic       parity_bit;
    logic [8:0] tx_word;
    logic [4:0] stop_bits;
    logic [4:0] data_bits;

    always_comb begin
        src_data   = (tsr_free | hold_wr) ? pwdata[7:0] : hold_r; // a write at frame end skips holding
        src_ninth  = (tsr_free | hold_wr) ? transmit_ninth_bit : hold_ninth_r;
        // parity from only the bits ahead of it; odd select inverts the sense
        if (nine_bit_select) begin
            parity_bit = (^src_data) ^ parity_odd_even_select; // [R23]
            tx_word    = {parity_enable ? parity_bit : src_ninth, src_data}; // [R13] [R14]
        end else begin
            parity_bit = (^src_data[6:0]) ^ parity_odd_even_select; // [R23]
            tx_word    = {1'b1, parity_enable ? parity_bit : src_data[7], src_data[6:0]}; // [R14] [R2]
        end
    end

    // frame length follows data and stop counts separately
    assign data_bits = nine_bit_select ? ufe_pkg::DATA_BITS_9 : ufe_pkg::DATA_BITS_8; // [R1]
    assign stop_bits = two_stop_select ? 5'h02 : 5'h01; // [R15]
    assign frame_len = tsr_break_r ? ufe_pkg::BREAK_LOW_BITS + stop_bits
                                   : ufe_pkg::START_BITS + data_bits + stop_bits; // [R16]

    logic last_bit;
    assign last_bit = baud_tick & (bit_cnt_r == frame_len - 5'h01);

    // holding register; emptied when the port is turned off, or when the transmitter is turned off while sending
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_r       <= 8'h00;
            hold_ninth_r <= 1'b0;
            hold_full_r  <= 1'b0;
        end else if (!tx_run & !(hold_wr & !transmit_enable)) begin
            if (!serial_enable | (tx_state_r == ufe_pkg::UFE_TX_SEND)) begin
                hold_full_r <= 1'b0; // [R10] [R20]
            end
        end else if (hold_wr & !tsr_free & !(last_bit & tx_run & (tx_state_r == ufe_pkg::UFE_TX_SEND))) begin
            hold_r       <= pwdata[7:0];
            hold_ninth_r <= transmit_ninth_bit;
            hold_full_r  <= 1'b1;
        end else if (last_bit & (tx_state_r == ufe_pkg::UFE_TX_SEND)) begin
            hold_full_r <= 1'b0; // [R17]
        end
    end

    // transmit flags: write clears, hardware setting wins over the write
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_empty_flag_r <= 1'b1;
            tx_idle_flag_r  <= 1'b1;
        end else if (!tx_run) begin
            tx_empty_flag_r <= ~hold_full_r | ~serial_enable; // [R11]
            tx_idle_flag_r  <= 1'b1; // [R11]
        end else begin
            if (last_bit & (tx_state_r == ufe_pkg::UFE_TX_SEND) & (hold_full_r | hold_wr)) begin
                tx_empty_flag_r <= 1'b1; // [R22]
            end else if (hold_wr) begin
                tx_empty_flag_r <= tsr_free; // [R19] [R22]
            end
            if (last_bit & (tx_state_r == ufe_pkg::UFE_TX_SEND)) begin
                tx_idle_flag_r <= 1'b1;
            end else if (hold_wr) begin
                tx_idle_flag_r <= 1'b0;
            end
        end
    end

    // transmit sequencer; leaving enable aborts and resets it at once
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state_r  <= ufe_pkg::UFE_TX_IDLE;
            tsr_r       <= 11'h7ff;
            tsr_break_r <= 1'b0;
            bit_cnt_r   <= 5'h00;
        end else if (!serial_enable) begin
            tx_state_r <= ufe_pkg::UFE_TX_IDLE; // [R12] [R10]
            bit_cnt_r  <= 5'h00;
        end else begin
            case (tx_state_r)
                ufe_pkg::UFE_TX_IDLE: begin
                    bit_cnt_r <= 5'h00;
                    if (hold_wr) begin
                        tsr_r       <= {1'b1, tx_word, 1'b0}; // [R19] [R4]
                        tsr_break_r <= 1'b0;
                        tx_state_r  <= ufe_pkg::UFE_TX_WAIT;
                    end else if (tx_run & send_break) begin
                        tsr_break_r <= 1'b1;
                        tx_state_r  <= ufe_pkg::UFE_TX_WAIT;
                    end
                end
                ufe_pkg::UFE_TX_WAIT: begin
                    // data may sit here until the transmitter is enabled
                    if (tx_run & baud_tick) begin
                        tx_state_r <= ufe_pkg::UFE_TX_SEND; // [R18]
                    end
                end
                ufe_pkg::UFE_TX_SEND: begin
                    if (!transmit_enable) begin
                        tx_state_r <= ufe_pkg::UFE_TX_IDLE; // [R20]
                        bit_cnt_r  <= 5'h00;
                    end else if (last_bit) begin
                        // reload only once the final stop bit has gone
                        bit_cnt_r <= 5'h00;
                        if (hold_full_r | hold_wr) begin
                            tsr_r       <= {1'b1, tx_word, 1'b0}; // [R17]
                            tsr_break_r <= 1'b0;
                        end else if (send_break) begin
                            tsr_break_r <= 1'b1;
                        end else begin
                            tx_state_r <= ufe_pkg::UFE_TX_IDLE;
                        end
                    end else if (baud_tick) begin
                        tsr_r     <= {1'b1, tsr_r[10:1]}; // [R4]
                        bit_cnt_r <= bit_cnt_r + 5'h01;
                    end
                end
                default: tx_state_r <= ufe_pkg::UFE_TX_IDLE;
            endcase
        end
    end

    // line level: high except while a frame shifts; stop bits fill with ones
    logic tx_bit;
    always_comb begin
        if ((tx_state_r != ufe_pkg::UFE_TX_SEND) | !tx_run) begin
            tx_bit = 1'b1; // [R9]
        end else if (tsr_break_r) begin
            tx_bit = (bit_cnt_r >= ufe_pkg::BREAK_LOW_BITS); // [R16]
        end else if (bit_cnt_r >= ufe_pkg::START_BITS + data_bits) begin
            tx_bit = 1'b1; // [R16]
        end else begin
            tx_bit = tsr_r[0];
        end
    end

    // pin ownership; released pins revert to the shared function
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_out <= 1'b1;
            tx_oe  <= 1'b0;
            rx_sel <= 1'b0;
        end else begin
            tx_out <= tx_bit; // [R9]
            tx_oe  <= tx_run; // [R8] [R20]
            rx_sel <= serial_enable & receive_enable; // [R8] [R10]
        end
    end

endmodule : ufe_uart

`default_nettype wire

// ---- verification/ufe_link_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module ufe_link_model (
    // clock
    input wire logic    core_clk,
    // line seen from the remote side
    input wire logic    line,
    input var int       period,
    input var int       nbits,
    output logic        rx_line,
    // last captured frame, lsb is the start bit
    output logic [11:0] got,
    output int          cnt
);
    logic [11:0] fr;
    // remote sender stays idle so the rx pin rests high
    assign rx_line = 1'b1;
    initial begin
        got = '1;
        cnt = 0;
    end
    // mid-bit sampling: a wrong bit period shows up as wrong bits
    always begin
        @(negedge line);
        fr = '1;
        repeat (period / 2) @(posedge core_clk);
        for (int i = 0; i < nbits; i++) begin
            fr[i] = line;
            if (i < nbits - 1) repeat (period) @(posedge core_clk);
        end
        got = fr;
        cnt++;
    end
endmodule : ufe_link_model
`default_nettype wire

// ---- verification/ufe_uart_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module ufe_uart_sva (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // serial pins
    input wire logic        tx_out,
    input wire logic        tx_oe,
    input wire logic        rx_in,
    input wire logic        rx_sel
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // decoded completed accesses
    wire logic acc = psel && penable && pready;
    wire logic wr1 = acc && pwrite && paddr == ufe_pkg::CTRL_ONE_OFS;
    wire logic wr2 = acc && pwrite && paddr == ufe_pkg::CTRL_TWO_OFS;
    wire logic unmap = paddr > ufe_pkg::HOLD_OFS || paddr[1:0] != 2'h0;
    // shortest bit is 16 clocks, so a start bit never ends early
    chk_start_len: assert property ($fell(tx_out) |=> (!tx_out || !tx_oe) [*8])
        else $error("start bit too short");
    chk_tx_owned: assert property ($fell(tx_out) |-> tx_oe)
        else $error("frame without pin ownership");
    chk_idle_high: assert property (!tx_oe [*3] |-> tx_out)
        else $error("released tx not high");
    chk_disable_pins: assert property (wr1 && !pwdata[7] |-> ##[1:2] (!tx_oe && !rx_sel))
        else $error("pins kept after disable");
    chk_transmit_enable_abort: assert property (wr2 && !pwdata[7] |-> ##[1:2] !tx_oe)
        else $error("tx pin kept after transmit disable");
    chk_oe_cause: assert property ($rose(tx_oe) |-> $past(wr1 || wr2) || $past(wr1 || wr2, 2))
        else $error("tx pin taken without control write");
    chk_hold_hidden: assert property (acc && !pwrite && paddr == ufe_pkg::HOLD_OFS |-> prdata == 32'h0)
        else $error("holding data readable");
    chk_zero_wait: assert property (psel && !penable ##1 psel && penable |-> pready)
        else $error("pready late");
    chk_err_decode: assert property (pready |-> psel && penable && pslverr == unmap)
        else $error("bad pready or pslverr");
    cover property ($fell(tx_out));
    cover property (acc && pslverr);
    cover property (wr1 && !pwdata[7] && tx_oe);
endmodule : ufe_uart_sva
bind ufe_uart ufe_uart_sva ufe_uart_sva_inst (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .tx_out(tx_out), .tx_oe(tx_oe), .rx_in(rx_in), .rx_sel(rx_sel));
`default_nettype wire

// ---- verification/ufe_uart_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module ufe_uart_tb;
    logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, tx_out, tx_oe, rx_in, rx_sel;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] got;
    logic        err;
    int          failures, n_tests, period, nbits, cnt, old;
    // released tx pin is pulled up
    wire logic   tx_line = tx_oe ? tx_out : 1'b1;
    ufe_uart ufe_uart_inst (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .tx_out(tx_out), .tx_oe(tx_oe), .rx_in(rx_in), .rx_sel(rx_sel));
    ufe_link_model ufe_link_model_inst (.core_clk(core_clk), .line(tx_line), .period(period),
        .nbits(nbits), .rx_line(rx_in), .got(got), .cnt(cnt));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic tally_and_finish;
        if (failures == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("mismatch %s exp %h got %h", nm, e, g);
            failures++;
        end
    endtask : chk
    // one apb transfer; waits for pready, only the watchdog ends a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'h1, 32'(n)); // answer due in the first access cycle
    endtask : apb
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rdchk
    task automatic wait_frame(input int o);
        int n;
        n = 0;
        while (cnt == o && n < 4000) begin
            @(posedge core_clk);
            n++;
        end
        chk("frame_seen", 32'h1, 32'(cnt != o));
    endtask : wait_frame
    // expected line bits, start bit first, stop bits already ones
    function automatic logic [11:0] expf(input logic [7:0] c1, input logic [7:0] d);
        logic [11:0] f;
        int          nd;
        logic        p;
        nd = c1[6] ? 9 : 8;
        f = '1;
        f[0] = 1'b0;
        p = c1[4];
        for (int i = 0; i < nd; i++) begin
            f[i + 1] = (i < 8) ? d[i] : c1[0];
            if (i < nd - 1) p = p ^ f[i + 1];
        end
        if (c1[5]) f[nd] = p;
        return f;
    endfunction : expf
    task automatic frame(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] dv, input logic [7:0] d);
        period = (c2[5] ? 16 : 64) * (dv + 1);
        nbits = (c1[6] ? 10 : 9) + (c1[3] ? 2 : 1);
        apb(1'b1, ufe_pkg::CTRL_ONE_OFS, {24'h0, c1});
        apb(1'b1, ufe_pkg::DIVISOR_OFS, {24'h0, dv});
        apb(1'b1, ufe_pkg::CTRL_TWO_OFS, {24'h0, c2});
        old = cnt;
        apb(1'b1, ufe_pkg::HOLD_OFS, {24'h0, d});
        wait_frame(old);
        chk("frame", {20'h0, expf(c1, d)}, {20'h0, got});
        repeat (period) @(posedge core_clk);
    endtask : frame
    initial begin
        repeat (40000) @(posedge core_clk);
        failures++;
        tally_and_finish;
    end
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        failures = 0;
        n_tests = 0;
        period = 64;
        nbits = 10;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        rdchk("ctrl1", ufe_pkg::CTRL_ONE_OFS, 32'h0);
        rdchk("ctrl2", ufe_pkg::CTRL_TWO_OFS, 32'h0);
        rdchk("status", ufe_pkg::STATUS_OFS, 32'h107);
        rdchk("hold", ufe_pkg::HOLD_OFS, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk("slverr", 32'h1, 32'(err));
        // formats, speeds and divisors
        frame(8'h80, 8'hc0, 8'h00, 8'ha5);
        frame(8'ha0, 8'he0, 8'h02, 8'h3c);
        frame(8'hb8, 8'hc0, 8'h01, 8'h81);
        frame(8'hc1, 8'he0, 8'h00, 8'h5a);
        frame(8'hf8, 8'he0, 8'h03, 8'hff);
        // back to back: shifter, then holding, third write refused
        old = cnt;
        apb(1'b1, ufe_pkg::HOLD_OFS, 32'h11);
        apb(1'b1, ufe_pkg::HOLD_OFS, 32'h22);
        rdchk("status_full", ufe_pkg::STATUS_OFS, 32'h104);
        apb(1'b1, ufe_pkg::HOLD_OFS, 32'h33);
        wait_frame(old);
        chk("first", {20'h0, expf(8'hf8, 8'h11)}, {20'h0, got});
        wait_frame(old + 1);
        chk("second", {20'h0, expf(8'hf8, 8'h22)}, {20'h0, got});
        repeat (900) @(posedge core_clk);
        chk("no_third", 32'(old + 2), 32'(cnt));
        // disable in mid frame, config kept, flags reset
        apb(1'b1, ufe_pkg::HOLD_OFS, 32'h0f);
        repeat (100) @(posedge core_clk);
        apb(1'b1, ufe_pkg::CTRL_ONE_OFS, 32'h78);
        rdchk("ctrl1_kept", ufe_pkg::CTRL_ONE_OFS, 32'h78);
        rdchk("ctrl2_cut", ufe_pkg::CTRL_TWO_OFS, 32'h20);
        rdchk("div_kept", ufe_pkg::DIVISOR_OFS, 32'h3);
        rdchk("status_off", ufe_pkg::STATUS_OFS, 32'h107);
        chk("pins_off", 32'h0, {30'h0, tx_oe, rx_sel});
        repeat (1000) @(posedge core_clk);
        // data loaded before transmit enable waits for it
        apb(1'b1, ufe_pkg::CTRL_ONE_OFS, 32'hf8);
        old = cnt;
        apb(1'b1, ufe_pkg::HOLD_OFS, 32'h6e);
        repeat (1000) @(posedge core_clk);
        chk("held", 32'(old), 32'(cnt));
        apb(1'b1, ufe_pkg::CTRL_TWO_OFS, 32'he0);
        wait_frame(old);
        chk("late_start", {20'h0, expf(8'hf8, 8'h6e)}, {20'h0, got});
        // transmit disable in mid frame aborts, releases the pin and empties the buffers
        apb(1'b1, ufe_pkg::HOLD_OFS, 32'h55);
        repeat (300) @(posedge core_clk);
        apb(1'b1, ufe_pkg::CTRL_TWO_OFS, 32'h20);
        repeat (2) @(posedge core_clk);
        chk("tx_abort", 32'h0, {31'h0, tx_oe});
        rdchk("status_abort", ufe_pkg::STATUS_OFS, 32'h107);
        tally_and_finish;
    end
endmodule : ufe_uart_tb
`default_nettype wire
